// ==== pllr_params.svh ====
// Constants for the reference path control block: register indices, field
// positions, masks and reset values.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef PLLR_PARAMS_SVH
`define PLLR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PLLR_CTRL_INDEX 6'h02
`define PLLR_STAT_INDEX 6'h10

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define PLLR_DIV_RST_BIT 22
`define PLLR_DIV_CODE_HI 21
`define PLLR_DIV_CODE_LO 20
`define PLLR_DBL_BIT 19
`define PLLR_EN_BIT 18
`define PLLR_DIV_SEL_BIT 17
`define PLLR_EDGE_BIT 16
`define PLLR_FB_HI 15
`define PLLR_FB_LO 8
`define PLLR_CTRL_WMASK 32'h007FFF7F
`define PLLR_CTRL_RESET 32'h00001900
`define PLLR_FB_MIN 8'h0A

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define PLLR_ST_EN_BIT 0
`define PLLR_ST_PATH_LO 1
`define PLLR_ST_EDGE_BIT 3
`define PLLR_ST_DIV_OUT_BIT 4
`define PLLR_ST_DIV_RST_BIT 5
`define PLLR_ST_MULT_LO 8

`endif

// ==== pllr_pkg.sv ====
// Types shared by the reference path control block.
// Assumes nothing beyond a SystemVerilog compiler.
package pllr_pkg;

  // Reference path in use ahead of the PLL.
  typedef enum logic [1:0] {
    PLLR_PATH_OFF  = 2'h0,
    PLLR_PATH_THRU = 2'h1,
    PLLR_PATH_DBL  = 2'h3,
    PLLR_PATH_DIV  = 2'h2
  } pllr_path_t;

endpackage : pllr_pkg

// ==== pllr_ref_div.sv ====
// Reference input divider: divides a sampled reference by 2, 4 or 8.
// Assumes the reference rising-edge pulse is already synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module pllr_ref_div #(
  parameter int CNT_W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ref_rise,
  input wire logic [1:0] div_code,
  input wire logic div_rst,
  output logic div_out,
  output logic div_rise
);

  // ----------------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------------
  if (CNT_W < 2) begin : g_bad_width
    $error("Divider counter must be at least two bits wide.");
  end

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] term;
  logic [CNT_W-1:0] next_cnt;
  logic next_out;
  wire active = ref_rise && !div_rst && (div_code != 2'h0);
  // Compare with at-or-above so a ratio change never strands the count past its end.
  wire wrap = (cnt >= term);

  // Half period in reference edges, less one, for each ratio.
  always_comb begin
    unique case (div_code)
      2'h1: term = CNT_W'(0);
      2'h2: term = CNT_W'(1);
      2'h3: term = CNT_W'(3);
      2'h0: term = CNT_W'(0);
    endcase
  end

  // Counter wraps each half period and toggles the output.
  assign next_cnt = wrap ? '0 : cnt + CNT_W'(1);
  assign next_out = wrap ? ~div_out : div_out;
  assign div_rise = active && wrap && !div_out;

  // Reset bit or bypass code holds the divider cleared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      div_out <= 1'b0;
    end else if (div_rst || div_code == 2'h0) begin
      cnt <= '0;
      div_out <= 1'b0;
    end else if (active) begin
      cnt <= next_cnt;
      div_out <= next_out;
    end
  end

endmodule : pllr_ref_div
`default_nettype wire

// ==== pllr_ctrl.sv ====
// Reference path control for the system-clock PLL, reached over APB.
// Assumes the reference clock input is sampled synchronously to pclk, and
// that pclk runs well above twice the reference rate.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pllr_params.svh"
module pllr_ctrl #(
  parameter int DIV_CNT_W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_clk_in,
  output logic pll_enable,
  output pllr_pkg::pllr_path_t pll_path,
  output logic pll_edge_falling,
  output logic pll_ref_tick,
  output logic [7:0] pll_fb_div,
  output logic [8:0] pll_mult
);
  import pllr_pkg::*;

  // ----------------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------------
  if (DIV_CNT_W < 2 || DIV_CNT_W > 8) begin : g_bad_param
    $error("Divider counter width must lie between 2 and 8.");
  end

  // ----------------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] strobed;
  logic [31:0] next_ctrl;
  logic [31:0] stat;
  logic [31:0] next_rdata;
  logic ref_q;
  logic div_out;
  logic div_rise;
  logic next_tick;

  // Bus phase and address decode.
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_ctrl = (paddr[7:2] == `PLLR_CTRL_INDEX) && (paddr[1:0] == 2'h0);
  wire hit_stat = (paddr[7:2] == `PLLR_STAT_INDEX) && (paddr[1:0] == 2'h0);
  wire unmapped = !hit_ctrl && !hit_stat;

  // Byte lanes merge the write data into the current control word.
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign strobed[8*b +: 8] = pstrb[b] ? pwdata[8*b +: 8] : ctrl[8*b +: 8];
  end
  assign next_ctrl = strobed & `PLLR_CTRL_WMASK;

  // A feedback value below the minimum is refused whole.
  wire bad_fb = next_ctrl[`PLLR_FB_HI:`PLLR_FB_LO] < `PLLR_FB_MIN;
  wire wr_ctrl = access && pwrite && hit_ctrl && !bad_fb;
  wire wr_err = access && pwrite && ((hit_ctrl && bad_fb) || hit_stat);

  // Zero wait states; errors for any unmapped access and for read-only or out-of-range writes.
  assign pready = 1'b1;
  assign pslverr = (access && unmapped) || wr_err;

  // ----------------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------------
  // The write takes effect at the access edge only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `PLLR_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  // Field decode of the control word.
  wire div_rst = ctrl[`PLLR_DIV_RST_BIT];
  wire [1:0] div_code = ctrl[`PLLR_DIV_CODE_HI:`PLLR_DIV_CODE_LO];
  wire dbl_sel = ctrl[`PLLR_DBL_BIT];
  wire div_sel = ctrl[`PLLR_DIV_SEL_BIT];
  wire edge_sel = ctrl[`PLLR_EDGE_BIT];

  // PLL enable and feedback multiplication.
  assign pll_enable = ctrl[`PLLR_EN_BIT];
  assign pll_fb_div = ctrl[`PLLR_FB_HI:`PLLR_FB_LO];
  assign pll_mult = {pll_fb_div, 1'b0};

  // Path selection: disable wins, then divider, then doubler, else feedthrough.
  assign pll_path = !pll_enable ? PLLR_PATH_OFF :
                    div_sel ? PLLR_PATH_DIV :
                    dbl_sel ? PLLR_PATH_DBL : PLLR_PATH_THRU;
  assign pll_edge_falling = (pll_path == PLLR_PATH_THRU) && edge_sel;

  // ----------------------------------------------------------------------------
  // Reference path
  // ----------------------------------------------------------------------------
  // Previous reference level for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_clk_in;
    end
  end
  wire ref_rise = ref_clk_in && !ref_q;
  wire ref_fall = !ref_clk_in && ref_q;

  // Reference input divider with its own reset bit.
  pllr_ref_div #(
    .CNT_W(DIV_CNT_W)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ref_rise(ref_rise),
    .div_code(div_code),
    .div_rst(div_rst),
    .div_out(div_out),
    .div_rise(div_rise)
  );

  // Reference event that the PLL phase detector sees for each path.
  always_comb begin
    unique case (pll_path)
      PLLR_PATH_OFF: next_tick = 1'b0;
      PLLR_PATH_DIV: next_tick = (div_code == 2'h0) ? ref_rise : div_rise;
      PLLR_PATH_THRU: next_tick = edge_sel ? ref_fall : ref_rise;
      PLLR_PATH_DBL: next_tick = ref_rise || ref_fall;
    endcase
  end

  // Registered so the event leaves the block from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_ref_tick <= 1'b0;
    end else begin
      pll_ref_tick <= next_tick;
    end
  end

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  // Status word shows the effective path state.
  always_comb begin
    stat = 32'h00000000;
    stat[`PLLR_ST_EN_BIT] = pll_enable;
    stat[`PLLR_ST_PATH_LO +: 2] = pll_path;
    stat[`PLLR_ST_EDGE_BIT] = pll_edge_falling;
    stat[`PLLR_ST_DIV_OUT_BIT] = div_out;
    stat[`PLLR_ST_DIV_RST_BIT] = div_rst;
    stat[`PLLR_ST_MULT_LO +: 9] = pll_mult;
  end
  assign next_rdata = hit_ctrl ? ctrl : hit_stat ? stat : 32'h00000000;

  // Read data is captured in the setup phase and held through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  // Divider reset keeps the divided output low.
  property p_div_held;
    @(posedge pclk) disable iff (!presetn)
      div_rst |=> !div_out;
  endproperty
  a_div_held: assert property (p_div_held) else $error("Divider ran while held in reset.");

  // Divide by two toggles the divided output on each reference rise.
  property p_div_two;
    @(posedge pclk) disable iff (!presetn)
      (div_code == 2'h1 && !div_rst && ref_rise) |=> (div_out != $past(div_out));
  endproperty
  a_div_two: assert property (p_div_two) else $error("Divide by two did not toggle.");

  // Divide code is ignored outside the divider path.
  property p_code_ignored;
    @(posedge pclk) disable iff (!presetn)
      (pll_enable && !div_sel && !dbl_sel && !edge_sel && ref_rise && div_code != 2'h0) |=> pll_ref_tick;
  endproperty
  a_code_ignored: assert property (p_code_ignored) else $error("Divide code altered the feedthrough.");

  // Doubler passes both reference edges.
  property p_doubler;
    @(posedge pclk) disable iff (!presetn)
      (pll_path == PLLR_PATH_DBL && ref_fall) |=> pll_ref_tick;
  endproperty
  a_doubler: assert property (p_doubler) else $error("Doubler missed a falling edge.");

  // A disabled PLL sees no reference events for two cycles.
  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
      (!ctrl[`PLLR_EN_BIT] && !wr_ctrl) |=> !pll_ref_tick ##1 (!pll_ref_tick || pll_enable);
  endproperty
  a_disabled: assert property (p_disabled) else $error("Reference event while PLL disabled.");

  // Divider path with a nonzero divide code passes only divided edges.
  property p_div_path;
    @(posedge pclk) disable iff (!presetn)
      (pll_path == PLLR_PATH_DIV && div_code != 2'h0 && ref_rise && !div_rise) |=> !pll_ref_tick;
  endproperty
  a_div_path: assert property (p_div_path) else $error("Undivided edge on divider path.");

  // Falling edge select on feedthrough passes falls and not rises.
  property p_edge_fall;
    @(posedge pclk) disable iff (!presetn)
      (pll_path == PLLR_PATH_THRU && edge_sel) |-> (ref_fall ##1 pll_ref_tick) or (!ref_fall ##1 !pll_ref_tick);
  endproperty
  a_edge_fall: assert property (p_edge_fall) else $error("Edge select not honoured.");

  // Edge select is ignored on the divider bypass path.
  property p_edge_ignored;
    @(posedge pclk) disable iff (!presetn)
      (pll_path == PLLR_PATH_DIV && div_code == 2'h0 && edge_sel && ref_fall) |=> !pll_ref_tick;
  endproperty
  a_edge_ignored: assert property (p_edge_ignored) else $error("Edge select leaked into divider path.");

  // Out-of-range feedback writes leave the value untouched and flag an error.
  property p_fb_refused;
    @(posedge pclk) disable iff (!presetn)
      (access && pwrite && hit_ctrl && bad_fb) |-> pslverr ##1 $stable(pll_fb_div);
  endproperty
  a_fb_refused: assert property (p_fb_refused) else $error("Bad feedback value accepted.");

endmodule : pllr_ctrl
`default_nettype wire

// ==== pllr_tb.sv ====
// Self-checking testbench for the reference path control block.
// Assumes pllr_pkg and pllr_ctrl are compiled first; APB is the only register bus.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pllr_pkg::*;

  // --------------------------------------------------------------------------
  // Signals and counters
  // --------------------------------------------------------------------------
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ref_clk_in;
  logic pll_enable;
  pllr_pkg::pllr_path_t pll_path;
  logic pll_edge_falling;
  logic pll_ref_tick;
  logic [7:0] pll_fb_div;
  logic [8:0] pll_mult;
  int n_mismatch = 0;
  int checks = 0;
  int ticks = 0;

  pllr_ctrl pllr_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_clk_in(ref_clk_in), .pll_enable(pll_enable), .pll_path(pll_path), .pll_edge_falling(pll_edge_falling),
    .pll_ref_tick(pll_ref_tick), .pll_fb_div(pll_fb_div), .pll_mult(pll_mult));

  // --------------------------------------------------------------------------
  // Clock, tick counting and helpers
  // --------------------------------------------------------------------------
  // The clock runs at 25 MHz.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Counts every reference event that reaches the PLL.
  always @(posedge pclk) begin
    if (pll_ref_tick === 1'b1) ticks <= ticks + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; answer values are taken as they stand at the edge where pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, s, r, e);
    chk({31'h0, e}, {31'h0, ee});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, 4'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask : rd

  // Sixteen reference periods of eight clocks each; the line rests low afterwards.
  task automatic burst(output logic [31:0] cnt);
    int t0;
    t0 = ticks;
    repeat (16) begin
      @(posedge pclk);
      ref_clk_in <= 1'b1;
      repeat (4) @(posedge pclk);
      ref_clk_in <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    cnt = 32'(ticks - t0);
  endtask : burst

  // Writes a control word, checks the path outputs and the tick count of one burst.
  task automatic cfg(input logic [31:0] w, input logic [1:0] p, input logic f, input logic [31:0] nt);
    logic [31:0] c;
    wr(8'h08, w, 4'hF, 1'b0);
    @(negedge pclk);
    chk({30'h0, pll_path}, {30'h0, p});
    chk({31'h0, pll_edge_falling}, {31'h0, f});
    chk({31'h0, pll_enable}, {31'h0, w[18]});
    burst(c);
    chk(c, nt);
  endtask : cfg

  task automatic stop_test;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  // Resets the block, then walks through register access and every path setting.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    ref_clk_in = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk({23'h0, pll_mult}, 32'h00000032);
    chk({30'h0, pll_path}, 32'h00000000);
    rd(8'h08, 32'h00001900, 1'b0);
    wr(8'h08, 32'h00000900, 4'h2, 1'b1);
    rd(8'h08, 32'h00001900, 1'b0);
    wr(8'h08, 32'h00000A00, 4'h2, 1'b0);
    @(negedge pclk);
    chk({23'h0, pll_mult}, 32'h00000014);
    rd(8'h0C, 32'h00000000, 1'b1);
    wr(8'h40, 32'h00000000, 4'hF, 1'b1);
    wr(8'h08, 32'hFFFFFFFF, 4'hF, 1'b0);
    rd(8'h08, 32'h007FFF7F, 1'b0);
    chk({24'h0, pll_fb_div}, 32'h000000FF);
    chk({23'h0, pll_mult}, 32'h000001FE);
    cfg(32'h00001900, 2'h0, 1'b0, 32'd0);
    // Software would calibrate through control register one after this enable; that register lies outside.
    cfg(32'h00041900, 2'h1, 1'b0, 32'd16);
    cfg(32'h00051900, 2'h1, 1'b1, 32'd16);
    rd(8'h40, 32'h0000320B, 1'b0);
    cfg(32'h00341900, 2'h1, 1'b0, 32'd16);
    cfg(32'h000D1900, 2'h3, 1'b0, 32'd32);
    cfg(32'h00061900, 2'h2, 1'b0, 32'd16);
    cfg(32'h00071900, 2'h2, 1'b0, 32'd16);
    cfg(32'h00161900, 2'h2, 1'b0, 32'd8);
    cfg(32'h00261900, 2'h2, 1'b0, 32'd4);
    cfg(32'h00361900, 2'h2, 1'b0, 32'd2);
    cfg(32'h00761900, 2'h2, 1'b0, 32'd0);
    rd(8'h40, 32'h00003225, 1'b0);
    cfg(32'h00361900, 2'h2, 1'b0, 32'd2);
    cfg(32'h003D1900, 2'h3, 1'b0, 32'd32);
    cfg(32'h00321900, 2'h0, 1'b0, 32'd0);
    stop_test();
  end

  // Cuts a hang short well beyond the few thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
